/* rtl/stc_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "stc_map.svh"

// Summary of operation
// - Host is bus controller; device only answers its own address, never starts transfers.
// - A write frame carries a command; a later read frame returns the response.
// - A read alone returns the current status.
// - Frame is an address byte (7-bit address, direction bit) then 0..255 bytes.
// - Own address with direction 0: take following bytes as a command.
// - Own address with direction 1: send the response message.
// - Target address comes from a field of the nonvolatile config word.
// - Status bits 7-6 zero, bit 5 RF command event, bit 4 field event.
// - Result code 0x0 nothing, 0x5 normal end, 0x7 busy.
// - Result code 0x1 on tunnel read detect, 0x3 on tunnel write detect.
// - Result code 0x8 for an unknown command code.
// - Result code 0xA for address outside memory or bad length.
// - Result code 0xB for writes into read-only memory; nothing is written.
// - Codes 0x08 read, 0x18 write, 0x68 control read, 0x78 control write.
// - Read response: status then data, data left out on error or busy.
// - Write command: code, address, length 0x01..0xFB, data; answer is status only.
// - Written bytes go to consecutive addresses from the start address.
// - Interrupt line goes low on completion, released when read address is acknowledged.
// - Read without preceding command returns just the status byte.
// - Control read answers status plus masks, RF stop, field and checksum flags.
module stc_top
  import stc_pkg::*;
#(
  parameter int MEM_DEPTH = `STC_MEM_DEPTH
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Two-wire link
  input wire logic scl_link_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic interrupt_request_n_out,
  // Nonvolatile configuration
  input wire logic [15:0] hardware_config_word_one_in,
  input wire logic [15:0] read_only_area_setting_in,
  // Device events and state
  input wire logic rf_command_event_in,
  input wire logic field_detect_event_in,
  input wire logic tunnel_read_event_in,
  input wire logic tunnel_write_event_in,
  input wire logic field_detected_in,
  input wire logic config_checksum_error_in,
  // Nonvolatile store port
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  output logic mem_we_out,
  input wire logic [7:0] mem_rdata_in,
  // Control outputs
  output logic rf_irq_mask_out,
  output logic field_irq_mask_out,
  output logic rf_stop_out,
  output logic self_reset_out
);
  stc_link_if lnk ();

  stc_frame_t frame_reg;
  logic [4:0] sync_w;
  logic [4:0] prev_reg;
  logic link_clear_n_reg;
  logic clear_armed_reg;
  logic [6:0] own_addr_reg;
  logic [7:0] cmd_reg;
  logic [15:0] addr_reg;
  logic [7:0] len_reg;
  logic [8:0] idx_reg;
  logic [7:0] ctl_wdata_reg;
  logic wr_ok_reg;
  logic [7:0] wr_left_reg;
  logic [15:0] wr_ptr_reg;
  logic [3:0] result_reg;
  logic resp_data_reg;
  logic resp_ctl_reg;
  logic status_sent_reg;
  logic reset_req_reg;
  logic rf_flag_reg;
  logic fd_flag_reg;
  logic [8:0] tx_idx_reg;
  logic [15:0] rd_addr_reg;
  logic [1:0] fetch_reg;
  logic [7:0] tx_byte_reg;
  logic sda_zero_reg;

  ////////////////////////////////////////////////////////////////////////
  // Pins and link toggles into the core clock
  stc_sync #(.WIDTH(5)) u_sync (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .d_in({scl_link_in, sda_in, lnk.rx_tgl, lnk.match_tgl, lnk.taken_tgl}),
    .q_out(sync_w)
  );

  stc_link u_link (
    .scl_link_in(scl_link_in),
    .sda_in(sda_in),
    .lnk(lnk)
  );

  // Edge and event decode on synchronised copies
  wire scl_s_w = sync_w[4];
  wire start_w = prev_reg[3] & ~sync_w[3] & scl_s_w & prev_reg[4];
  wire stop_w = ~prev_reg[3] & sync_w[3] & scl_s_w & prev_reg[4];
  wire frame_end_w = start_w | stop_w;
  // Clearing the link drops its toggles to zero; masked so that is no event
  wire rx_ev_w = (sync_w[2] ^ prev_reg[2]) & link_clear_n_reg;
  wire match_ev_w = (sync_w[1] ^ prev_reg[1]) & link_clear_n_reg;
  wire taken_ev_w = (sync_w[0] ^ prev_reg[0]) & link_clear_n_reg;

  // Parameter checks; a 17-bit sum avoids wrap past 0xffff
  wire [16:0] end_w = {1'b0, addr_reg} + {9'h000, len_reg};
  wire [16:0] end_rx_w = {1'b0, addr_reg} + {9'h000, lnk.rx_byte};
  wire range_ok_w = end_w <= 17'(MEM_DEPTH);
  wire rd_len_ok_w = len_reg >= `STC_LEN_MIN && len_reg <= `STC_RD_LEN_MAX;
  wire wr_len_ok_w = len_reg >= `STC_LEN_MIN && len_reg <= `STC_WR_LEN_MAX;
  wire ro_hit_w = addr_reg < read_only_area_setting_in;
  wire wr_ok_w = cmd_reg == `STC_CMD_MEM_WRITE && lnk.rx_byte >= `STC_LEN_MIN
    && lnk.rx_byte <= `STC_WR_LEN_MAX && end_rx_w <= 17'(MEM_DEPTH)
    && !ro_hit_w;
  wire have_params_w = idx_reg >= 9'd4;

  // Result of a finished command frame
  wire is_rd_w = cmd_reg == `STC_CMD_MEM_READ;
  wire is_wr_w = cmd_reg == `STC_CMD_MEM_WRITE;
  wire is_cr_w = cmd_reg == `STC_CMD_CTL_READ;
  wire is_cw_w = cmd_reg == `STC_CMD_CTL_WRITE;
  wire rd_good_w = have_params_w & rd_len_ok_w & range_ok_w;
  wire wr_good_w = have_params_w & wr_len_ok_w & range_ok_w;
  wire [3:0] final_code_w =
    is_rd_w ? (rd_good_w ? `STC_RES_OK : `STC_RES_PARAM) :
    is_wr_w ? (!wr_good_w ? `STC_RES_PARAM :
               ro_hit_w ? `STC_RES_READ_ONLY : `STC_RES_OK) :
    is_cr_w ? `STC_RES_OK :
    is_cw_w ? (idx_reg >= 9'd2 ? `STC_RES_OK : `STC_RES_PARAM) :
    `STC_RES_UNKNOWN;
  wire cmd_done_w = frame_end_w && frame_reg == FR_WRITE && idx_reg != 9'd0;
  wire read_done_w = frame_end_w && frame_reg == FR_READ;
  wire soft_reset_w = read_done_w & status_sent_reg & reset_req_reg;

  // Status and control bytes as the host sees them
  wire busy_w = frame_reg == FR_WRITE;
  wire [3:0] code_w = busy_w ? `STC_RES_BUSY : result_reg;
  wire [7:0] status_w = {2'b00, rf_flag_reg, fd_flag_reg, code_w};
  wire [7:0] ctl_byte_w = {1'b0, rf_irq_mask_out, field_irq_mask_out, rf_stop_out,
    field_detected_in, 2'b00, config_checksum_error_in};
  wire clr_flags_w = frame_reg == FR_READ && taken_ev_w && tx_idx_reg == 9'd0;
  wire more_data_w = resp_data_reg && result_reg == `STC_RES_OK
    && tx_idx_reg < {1'b0, len_reg};

  ////////////////////////////////////////////////////////////////////////
  // Link reset: held while the bus is idle, freed after a start once SCL is low
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prev_reg <= 5'h00;
      link_clear_n_reg <= 1'b0;
      clear_armed_reg <= 1'b0;
      own_addr_reg <= 7'h00;
    end else begin
      prev_reg <= sync_w;
      own_addr_reg <= hardware_config_word_one_in[`STC_TADDR_LSB +: 7];
      if (frame_end_w) begin
        link_clear_n_reg <= 1'b0;
        clear_armed_reg <= start_w;
      end else if (clear_armed_reg && !scl_s_w) begin
        link_clear_n_reg <= 1'b1;
        clear_armed_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame tracking and command byte capture
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      frame_reg <= FR_NONE;
      idx_reg <= 9'h000;
      cmd_reg <= 8'h00;
      addr_reg <= 16'h0000;
      len_reg <= 8'h00;
      ctl_wdata_reg <= 8'h00;
    end else if (frame_end_w) begin
      frame_reg <= FR_NONE;
    end else if (match_ev_w) begin
      frame_reg <= lnk.match_read ? FR_READ : FR_WRITE;
      if (!lnk.match_read) begin
        idx_reg <= 9'h000;
      end
    end else if (rx_ev_w && frame_reg == FR_WRITE) begin
      if (idx_reg != 9'h1ff) begin
        idx_reg <= idx_reg + 9'd1;
      end
      if (idx_reg == 9'd0) begin
        cmd_reg <= lnk.rx_byte;
      end
      if (idx_reg == 9'd1) begin
        addr_reg[15:8] <= lnk.rx_byte;
        ctl_wdata_reg <= lnk.rx_byte;
      end
      if (idx_reg == 9'd2) begin
        addr_reg[7:0] <= lnk.rx_byte;
      end
      if (idx_reg == 9'd3) begin
        len_reg <= lnk.rx_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory writes as data bytes arrive; the range was checked at the length byte
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ok_reg <= 1'b0;
      wr_left_reg <= 8'h00;
      wr_ptr_reg <= 16'h0000;
      mem_we_out <= 1'b0;
      mem_wdata_out <= 8'h00;
      mem_addr_out <= 16'h0000;
      fetch_reg <= 2'b00;
    end else begin
      mem_we_out <= 1'b0;
      fetch_reg <= {fetch_reg[0], 1'b0};
      if (rx_ev_w && frame_reg == FR_WRITE && idx_reg == 9'd3) begin
        wr_ok_reg <= wr_ok_w;
        wr_left_reg <= lnk.rx_byte;
        wr_ptr_reg <= addr_reg;
      end else if (rx_ev_w && frame_reg == FR_WRITE && have_params_w && wr_ok_reg
                   && wr_left_reg != 8'h00) begin
        mem_we_out <= 1'b1;
        mem_wdata_out <= lnk.rx_byte;
        mem_addr_out <= wr_ptr_reg;
        wr_ptr_reg <= wr_ptr_reg + 16'd1;
        wr_left_reg <= wr_left_reg - 8'd1;
      end else if (taken_ev_w && frame_reg == FR_READ && more_data_w) begin
        mem_addr_out <= rd_addr_reg;
        fetch_reg <= 2'b01;
      end
      if (frame_end_w) begin
        wr_ok_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Response byte staging; the status byte stands ready outside read frames
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_byte_reg <= 8'h00;
      tx_idx_reg <= 9'h000;
      rd_addr_reg <= 16'h0000;
    end else if (frame_reg != FR_READ) begin
      tx_byte_reg <= status_w;
      tx_idx_reg <= 9'h000;
      rd_addr_reg <= addr_reg;
    end else if (fetch_reg[1]) begin
      tx_byte_reg <= mem_rdata_in;
    end else if (taken_ev_w) begin
      tx_idx_reg <= tx_idx_reg + 9'd1;
      if (more_data_w) begin
        rd_addr_reg <= rd_addr_reg + 16'd1;
      end else if (resp_ctl_reg && tx_idx_reg == 9'd0) begin
        tx_byte_reg <= ctl_byte_w;
      end else begin
        tx_byte_reg <= `STC_FILL_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result, response kind and interrupt line
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result_reg <= `STC_RES_NONE;
      resp_data_reg <= 1'b0;
      resp_ctl_reg <= 1'b0;
      status_sent_reg <= 1'b0;
      interrupt_request_n_out <= 1'b1;
    end else if (cmd_done_w) begin
      result_reg <= final_code_w;
      resp_data_reg <= is_rd_w && final_code_w == `STC_RES_OK;
      resp_ctl_reg <= is_cr_w;
      status_sent_reg <= 1'b0;
      interrupt_request_n_out <= 1'b0;
    end else if (read_done_w && status_sent_reg) begin
      result_reg <= `STC_RES_NONE; // Response delivered, nothing left to report
      resp_data_reg <= 1'b0;
      resp_ctl_reg <= 1'b0;
      status_sent_reg <= 1'b0;
    end else begin
      if (match_ev_w && lnk.match_read) begin
        interrupt_request_n_out <= 1'b1;
      end
      if (clr_flags_w) begin
        status_sent_reg <= 1'b1;
      end
      if (frame_reg == FR_NONE && (tunnel_read_event_in || tunnel_write_event_in)) begin
        result_reg <= tunnel_read_event_in ? `STC_RES_TUN_READ
          : `STC_RES_TUN_WRITE;
        interrupt_request_n_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event flags: an event in the clearing cycle wins over the clear
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rf_flag_reg <= 1'b0;
      fd_flag_reg <= 1'b0;
    end else begin
      rf_flag_reg <= rf_command_event_in | (rf_flag_reg & ~clr_flags_w & ~soft_reset_w);
      fd_flag_reg <= field_detect_event_in | (fd_flag_reg & ~clr_flags_w & ~soft_reset_w);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control byte; reset request waits until its status has been read out
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rf_irq_mask_out <= 1'b0;
      field_irq_mask_out <= 1'b0;
      rf_stop_out <= 1'b0;
      reset_req_reg <= 1'b0;
      self_reset_out <= 1'b0;
    end else begin
      self_reset_out <= soft_reset_w;
      if (soft_reset_w) begin
        rf_irq_mask_out <= 1'b0;
        field_irq_mask_out <= 1'b0;
        rf_stop_out <= 1'b0;
        reset_req_reg <= 1'b0;
      end else if (cmd_done_w && is_cw_w && idx_reg >= 9'd2) begin
        rf_irq_mask_out <= ctl_wdata_reg[`STC_CTL_RF_MASK];
        field_irq_mask_out <= ctl_wdata_reg[`STC_CTL_FD_MASK];
        rf_stop_out <= ctl_wdata_reg[`STC_CTL_RF_STOP];
        reset_req_reg <= ctl_wdata_reg[`STC_CTL_RESET];
      end
    end
  end

  // Open-drain data pin only ever pulls low
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sda_zero_reg <= 1'b0;
    end else begin
      sda_zero_reg <= 1'b0;
    end
  end

  // Crossing outputs from stable core flops; sda_oe_out comes from the link-side flop
  assign lnk.clear_n = link_clear_n_reg;
  assign lnk.own_addr = own_addr_reg;
  assign lnk.tx_byte = tx_byte_reg;
  assign sda_out = sda_zero_reg;
  assign sda_oe_out = lnk.sda_oe;
endmodule // stc_top

`default_nettype wire

/* rtl/stc_map.svh */
`ifndef STC_MAP_SVH
`define STC_MAP_SVH

// Memory size in bytes
`define STC_MEM_DEPTH 512

// Command codes
`define STC_CMD_MEM_READ 8'h08
`define STC_CMD_MEM_WRITE 8'h18
`define STC_CMD_CTL_READ 8'h68
`define STC_CMD_CTL_WRITE 8'h78

// Result codes in status bits 3-0
`define STC_RES_NONE 4'h0
`define STC_RES_TUN_READ 4'h1
`define STC_RES_TUN_WRITE 4'h3
`define STC_RES_OK 4'h5
`define STC_RES_BUSY 4'h7
`define STC_RES_UNKNOWN 4'h8
`define STC_RES_PARAM 4'ha
`define STC_RES_READ_ONLY 4'hb

// Length limits
`define STC_LEN_MIN 8'h01
`define STC_RD_LEN_MAX 8'hfe
`define STC_WR_LEN_MAX 8'hfb

// Control byte fields
`define STC_CTL_RF_MASK 6
`define STC_CTL_FD_MASK 5
`define STC_CTL_RF_STOP 4
`define STC_CTL_FD_SEEN 3
`define STC_CTL_CHK_ERR 0
`define STC_CTL_RESET 0

// Target address field position in the config word
`define STC_TADDR_LSB 0

// Byte sent once a response is used up
`define STC_FILL_BYTE 8'hff

`endif

/* rtl/stc_pkg.sv */
package stc_pkg;

  // Kind of frame the core is tracking
  typedef enum logic [1:0] {
    FR_NONE,
    FR_WRITE,
    FR_READ
  } stc_frame_t;

  // Phase of the link-side bit engine
  typedef enum logic [1:0] {
    PH_ADDR,
    PH_WRITE,
    PH_READ,
    PH_IGNORE
  } stc_phase_t;

endpackage

/* rtl/stc_link_if.sv */
`timescale 1ns/10ps
`default_nettype none

// Signals crossing between core and link domains
interface stc_link_if;
  logic clear_n;
  logic [6:0] own_addr;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic rx_tgl;
  logic match_tgl;
  logic match_read;
  logic taken_tgl;
  logic sda_oe;

  modport core (
    output clear_n, own_addr, tx_byte,
    input rx_byte, rx_tgl, match_tgl, match_read, taken_tgl, sda_oe
  );
  modport link (
    input clear_n, own_addr, tx_byte,
    output rx_byte, rx_tgl, match_tgl, match_read, taken_tgl, sda_oe
  );
endinterface

`default_nettype wire

/* rtl/stc_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module stc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Data
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;

  // Two-stage synchroniser; only the second stage is visible
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= '0;
      q_out <= '0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule // stc_sync

`default_nettype wire

/* rtl/stc_link.sv */
`timescale 1ns/10ps
`default_nettype none
`include "stc_map.svh"

module stc_link
  import stc_pkg::*;
(
  // Link clock and data pin
  input wire logic scl_link_in,
  input wire logic sda_in,
  // Crossing signals
  stc_link_if.link lnk
);
  stc_phase_t phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic ack_req_reg;
  logic [7:0] rx_byte_reg;
  logic rx_tgl_reg;
  logic match_tgl_reg;
  logic match_read_reg;
  logic [7:0] tx_shift_reg;
  logic sda_oe_reg;
  logic taken_tgl_reg;

  // Byte decode at the eighth rising edge
  wire [7:0] byte_w = {shift_reg, sda_in};
  wire last_bit_w = (bit_cnt_reg == 4'd7);
  wire match_w = (byte_w[7:1] == lnk.own_addr);

  ////////////////////////////////////////////////////////////////////////
  // Rising edge: sample data, decode address, master acknowledge
  always_ff @(posedge scl_link_in or negedge lnk.clear_n) begin
    if (!lnk.clear_n) begin
      phase_reg <= PH_ADDR;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 7'h00;
      ack_req_reg <= 1'b0;
      rx_byte_reg <= 8'h00;
      rx_tgl_reg <= 1'b0;
      match_tgl_reg <= 1'b0;
      match_read_reg <= 1'b0;
    end else if (bit_cnt_reg == 4'd8) begin
      bit_cnt_reg <= 4'h0;
      ack_req_reg <= 1'b0;
      if (phase_reg == PH_READ && sda_in) begin
        phase_reg <= PH_IGNORE; // Master NACK ends the response
      end
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'd1;
      shift_reg <= byte_w[6:0];
      if (last_bit_w) begin
        unique case (phase_reg)
          PH_ADDR: begin
            if (match_w) begin
              phase_reg <= byte_w[0] ? PH_READ : PH_WRITE;
              match_read_reg <= byte_w[0];
              match_tgl_reg <= ~match_tgl_reg;
              ack_req_reg <= 1'b1;
            end else begin
              phase_reg <= PH_IGNORE; // Target only answers its own address
            end
          end
          PH_WRITE: begin
            rx_byte_reg <= byte_w;
            rx_tgl_reg <= ~rx_tgl_reg;
            ack_req_reg <= 1'b1;
          end
          PH_READ, PH_IGNORE: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Falling edge: drive acknowledge or response bits
  // Core keeps tx_byte stable well ahead of the load, so no extra sync here
  always_ff @(negedge scl_link_in or negedge lnk.clear_n) begin
    if (!lnk.clear_n) begin
      tx_shift_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
      taken_tgl_reg <= 1'b0;
    end else if (bit_cnt_reg == 4'd8) begin
      sda_oe_reg <= ack_req_reg;
    end else if (bit_cnt_reg == 4'd0 && phase_reg == PH_READ) begin
      tx_shift_reg <= {lnk.tx_byte[6:0], 1'b0};
      sda_oe_reg <= ~lnk.tx_byte[7];
      taken_tgl_reg <= ~taken_tgl_reg;
    end else if (phase_reg == PH_READ) begin
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      sda_oe_reg <= ~tx_shift_reg[7];
    end else begin
      sda_oe_reg <= 1'b0;
    end
  end

  // Outputs to the core
  assign lnk.rx_byte = rx_byte_reg;
  assign lnk.rx_tgl = rx_tgl_reg;
  assign lnk.match_tgl = match_tgl_reg;
  assign lnk.match_read = match_read_reg;
  assign lnk.taken_tgl = taken_tgl_reg;
  assign lnk.sda_oe = sda_oe_reg;
endmodule // stc_link

`default_nettype wire

/* bench/stc_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module stc_monitor #(
  parameter int MEM_DEPTH = 512
) (
  // Core clock, reset and setting
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [15:0] read_only_area_setting_in,
  // Pins watched
  input wire logic scl_link_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic interrupt_request_n_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic mem_we_out,
  input wire logic rf_irq_mask_out,
  input wire logic self_reset_out
);
  logic [3:0] since_ack_reg;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the device last pulled the data line
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) since_ack_reg <= 4'h0;
    else if (sda_oe_out) since_ack_reg <= 4'h0;
    else if (since_ack_reg != 4'hf) since_ack_reg <= since_ack_reg + 4'h1;
  end
  // A store strobe is followed by a quiet gap
  sequence we_gap;
    !mem_we_out [*8];
  endsequence
  // Self reset only on an idle bus, one cycle long
  sequence idle_pulse;
    scl_link_in ##1 !self_reset_out;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  sda_zero_a: assert property (sda_out == 1'b0)
    else $error("data output not low");
  oe_edge_a: assert property ($changed(sda_oe_out) |-> !scl_link_in)
    else $error("data line moved while link clock high");
  irq_rel_a: assert property ($rose(interrupt_request_n_out) |-> since_ack_reg < 4'h8)
    else $error("interrupt released without acknowledge");
  we_pulse_a: assert property (mem_we_out |=> we_gap)
    else $error("store strobe too long");
  we_range_a: assert property (mem_we_out |-> mem_addr_out < MEM_DEPTH)
    else $error("store write outside memory");
  we_ro_a: assert property (mem_we_out |-> mem_addr_out >= read_only_area_setting_in)
    else $error("store write into protected area");
  mask_stop_a: assert property ($changed(rf_irq_mask_out) |-> scl_link_in)
    else $error("mask changed inside a frame");
  reset_req_a: assert property (self_reset_out |-> idle_pulse)
    else $error("self reset badly timed");
endmodule // stc_monitor

bind stc_top stc_monitor #(.MEM_DEPTH(MEM_DEPTH)) u_mon (
  .clock_in(clock_in),
  .nrst_in(nrst_in),
  .read_only_area_setting_in(read_only_area_setting_in),
  .scl_link_in(scl_link_in),
  .sda_out(sda_out),
  .sda_oe_out(sda_oe_out),
  .interrupt_request_n_out(interrupt_request_n_out),
  .mem_addr_out(mem_addr_out),
  .mem_we_out(mem_we_out),
  .rf_irq_mask_out(rf_irq_mask_out),
  .self_reset_out(self_reset_out)
);
`default_nettype wire

/* bench/stc_host.sv */
`timescale 1ns/10ps
`default_nettype none
// Bus controller model, the only party that clocks the link
module stc_host (
  // Link lines
  output logic scl_out,
  output logic sda_low_out,
  input wire logic sda_in
);
  localparam realtime HALF = 62.5;
  // Link clock stands high between frames
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Start or repeated start; long low after it lets the target wake
  task automatic start();
    sda_low_out = 1'b0;
    #300;
    scl_out = 1'b1;
    #300;
    sda_low_out = 1'b1;
    #400;
    scl_out = 1'b0;
    #400;
  endtask
  // Stop, then idle bus
  task automatic stop();
    sda_low_out = 1'b1;
    #300;
    scl_out = 1'b1;
    #300;
    sda_low_out = 1'b0;
    #1000;
  endtask
  // Eight bits MSB first then acknowledge; clock held low before it
  task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
    output logic ack_out);
    logic [8:0] v;
    v = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      sda_low_out = !v[i];
      if (i == 0) #1000;
      #HALF;
      scl_out = 1'b1;
      #HALF;
      v[i] = sda_in;
      scl_out = 1'b0;
    end
    sda_low_out = 1'b0;
    rx = v[8:1];
    ack_out = v[0];
  endtask
endmodule // stc_host
`default_nettype wire

/* bench/stc_top_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module stc_top_bench;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic scl, sda_low, sda_oe, sda_o, irq_n, we, rfm, fdm, stp, srst;
  logic [15:0] cfg = 16'h002a;
  logic [15:0] maddr;
  logic [7:0] wdata;
  logic [3:0] ev = 4'h0;
  logic [1:0] lvl = 2'h0;
  logic [7:0] mem [512];
  // Pulled-up wire seen by both ends
  wire logic sda_w = !(sda_low || (sda_oe && !sda_o));
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_rst = 0;
  always #25 clock_in = !clock_in;
  // Store model and self reset counter
  always @(posedge clock_in) if (we) mem[maddr[8:0]] <= wdata;
  always @(negedge clock_in) if (srst === 1'b1) n_rst++;
  stc_top DUT (.clock_in(clock_in), .nrst_in(nrst_in), .scl_link_in(scl), .sda_in(sda_w),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .interrupt_request_n_out(irq_n),
    .hardware_config_word_one_in(cfg), .read_only_area_setting_in(16'h0010),
    .rf_command_event_in(ev[3]), .field_detect_event_in(ev[2]), .tunnel_read_event_in(ev[1]),
    .tunnel_write_event_in(ev[0]), .field_detected_in(lvl[1]),
    .config_checksum_error_in(lvl[0]), .mem_addr_out(maddr), .mem_wdata_out(wdata),
    .mem_we_out(we), .mem_rdata_in(mem[maddr[8:0]]), .rf_irq_mask_out(rfm),
    .field_irq_mask_out(fdm), .rf_stop_out(stp), .self_reset_out(srst));
  stc_host host (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda_w));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Command frame, then wait for completion
  task automatic send(input logic [7:0] q[$]);
    logic [7:0] r;
    logic a;
    host.start();
    host.byte_io({cfg[6:0], 1'b0}, 1'b1, r, a);
    check({7'h0, a}, 8'h00);
    foreach (q[i]) host.byte_io(q[i], 1'b1, r, a);
    host.stop();
    for (int i = 0; i < 99 && irq_n !== 1'b0; i++) @(negedge clock_in);
    check({7'h0, irq_n}, 8'h00);
  endtask
  // Response frame; the host refuses the last byte
  task automatic fetch(input int n, output logic [7:0] r[$]);
    logic [7:0] b;
    logic a;
    r = {};
    host.start();
    host.byte_io({cfg[6:0], 1'b1}, 1'b1, b, a);
    check({7'h0, a}, 8'h00);
    for (int i = 0; i < n; i++) begin
      host.byte_io(8'hff, i == n - 1, b, a);
      r.push_back(b);
    end
    host.stop();
    check({7'h0, irq_n}, 8'h01);
  endtask
  // Refused command: code only, data left out
  task automatic err(input logic [7:0] q[$], input logic [3:0] code);
    logic [7:0] r[$];
    send(q);
    fetch(2, r);
    check(r[0], {4'h0, code});
    check(r[1], 8'hff);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_status();
    logic [7:0] r[$];
    logic [7:0] b;
    logic a;
    fetch(2, r);
    check(r[0], 8'h00);
    check(r[1], 8'hff);
    host.start();
    host.byte_io(8'h56, 1'b1, b, a);
    host.stop();
    check({7'h0, a}, 8'h01);
    @(negedge clock_in);
    cfg = 16'h0035;
    fetch(1, r);
    check(r[0], 8'h00);
  endtask
  task automatic t_mem();
    logic [7:0] r[$];
    send('{8'h18, 8'h01, 8'h00, 8'h02, 8'ha5, 8'h5a});
    fetch(2, r);
    check(r[0], 8'h05);
    check(r[1], 8'hff);
    check(mem[256], 8'ha5);
    check(mem[257], 8'h5a);
    send('{8'h08, 8'h01, 8'h00, 8'h02});
    fetch(4, r);
    check(r[0], 8'h05);
    check(r[1], 8'ha5);
    check(r[2], 8'h5a);
    check(r[3], 8'hff);
  endtask
  task automatic t_errors();
    err('{8'h08, 8'h01, 8'h00, 8'h00}, 4'ha);
    err('{8'h08, 8'h02, 8'h00, 8'h01}, 4'ha);
    err('{8'h18, 8'h01, 8'h00, 8'hfc}, 4'ha);
    err('{8'h55}, 4'h8);
    err('{8'h18, 8'h00, 8'h04, 8'h01, 8'h77}, 4'hb);
    check(mem[4], 8'h00);
  endtask
  task automatic t_events();
    logic [7:0] r[$];
    logic [7:0] exp [4] = '{8'h20, 8'h10, 8'h01, 8'h03};
    for (int i = 0; i < 4; i++) begin
      @(negedge clock_in);
      ev = 4'h8 >> i;
      @(negedge clock_in);
      ev = 4'h0;
      repeat (5) @(negedge clock_in);
      fetch(1, r);
      check(r[0], exp[i]);
    end
  endtask
  task automatic t_ctl();
    logic [7:0] r[$];
    @(negedge clock_in);
    lvl = 2'h3;
    send('{8'h78, 8'h70});
    check({5'h0, rfm, fdm, stp}, 8'h07);
    fetch(1, r);
    send('{8'h68});
    fetch(3, r);
    check(r[0], 8'h05);
    check(r[1], 8'h79);
    send('{8'h78, 8'h01});
    check(n_rst[7:0], 8'h00);
    fetch(1, r);
    check(r[0], 8'h05);
    repeat (20) @(negedge clock_in);
    check(n_rst[7:0], 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; reset held for ten cycles
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (10) @(negedge clock_in);
    nrst_in = 1'b1;
    repeat (5) @(negedge clock_in);
    t_status();
    t_mem();
    t_errors();
    t_events();
    t_ctl();
    conclude();
  end
  // Hang guard, well beyond the expected run
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      conclude();
    end
  end
endmodule // stc_top_bench
`default_nettype wire
